// ### src/ceb_defines.vh
// constants for the clock output enable bank
`ifndef CEB_DEFINES_VH
`define CEB_DEFINES_VH

// serial bus addresses, full byte including direction bit
`define CEB_ADDR_WRITE 8'hd2
`define CEB_ADDR_READ  8'hd3

// byte count returned first on a block read
`define CEB_READ_COUNT 8'h06

// register indices, in data byte order
`define CEB_IDX_FUNC   3'h0
`define CEB_IDX_CPU    3'h1
`define CEB_IDX_PCI    3'h2
`define CEB_IDX_MEM    3'h3
`define CEB_IDX_SEL    3'h4
`define CEB_IDX_PERIPH 3'h5
`define CEB_IDX_LAST   3'h5

// power-up values: every enable and reserved bit set
`define CEB_RST_ENABLES 8'hff
`define CEB_RST_FUNC    8'h00

// writable masks; other bits read as one, except the cpu and memory select status bits
`define CEB_WMASK_CPU    8'h0b
`define CEB_WMASK_PCI    8'h5f
`define CEB_WMASK_MEM    8'h37
`define CEB_WMASK_PERIPH 8'h13

// enable bit positions
`define CEB_CPU_MEMF   3
`define CEB_CPU_STOP   1
`define CEB_CPU_FREE   0
`define CEB_PCI_FREE   6
`define CEB_MEM_48     5
`define CEB_MEM_24     4
`define CEB_MEM_G2     2
`define CEB_MEM_G1     1
`define CEB_MEM_G0     0
`define CEB_PER_INTC   4
`define CEB_PER_REFB   1
`define CEB_PER_REFA   0

// status bit positions of the inverted latched selects
`define CEB_CPU_SEL2   7
`define CEB_MEM_SEL0   6
`define CEB_SEL_SEL1   3
`define CEB_SEL_SEL3   1

// cycles after reset release before select pins are trusted;
// the filter output is only valid after the fourth edge, so capture on the fifth
`define CEB_LATCH_WAIT 3'h4

`endif

// ### src/ceb_sync.v
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module ceb_sync #(
  parameter W    = 1,
  parameter INIT = 1'b0
) (
  // clock and reset
  input  wire         clk,
  input  wire         nrst,
  // asynchronous input and filtered result
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] s1_q;   // first stage, read only by s2
  reg [W-1:0] s2_q;   // second stage
  reg [W-1:0] s3_q;   // third stage
  reg [W-1:0] out_q;  // accepted value

  // a change is taken only once stages two and three agree
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q  <= {W{INIT}};
      s2_q  <= {W{INIT}};
      s3_q  <= {W{INIT}};
      out_q <= {W{INIT}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        out_q <= s3_q;
      end
    end
  end

  assign dout = out_q;
endmodule // ceb_sync

// ### src/ceb_bank.v
// clock output enable bank with its serial programming slave
//
// Function
// - cpu byte gates memory, stoppable, free clocks
// - pci byte gates free and five bus clocks
// - memory byte gates 48, 24, three groups
// - peripheral byte gates interrupt and reference clocks
// - select byte reserved, two select status bits
// - disabled output held low, no toggling
// - status reads inverse of latched select pin
// - write: address, ignored command, count, data
// - read: address, count, then bytes zero-five
// - ascending bytes, stop ends loading anywhere
`timescale 1ns/1ps
`include "ceb_defines.vh"
module ceb_bank (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // serial programming pins
  input  wire        sclIn,
  input  wire        sdaIn,
  output wire        sdaOut,
  output wire        sdaOe,
  // frequency select straps
  input  wire [3:0]  freqSelectPins,
  // ungated clock sources, same clock domain
  input  wire        procClkSrc,
  input  wire        busClkSrc,
  input  wire        memClkSrc,
  input  wire        clk48Src,
  input  wire        clk24Src,
  input  wire        refClkSrc,
  // gated clock outputs
  output wire        freeMemoryClock,
  output wire        stoppableProcClock,
  output wire        freeProcClock,
  output wire        freeBusClock,
  output wire [4:0]  busClockOutputs,
  output wire        clk48Out,
  output wire        clk24Out,
  output wire [11:0] memClockGroups,
  output wire        interruptCtrlClock,
  output wire        referenceClockA,
  output wire        referenceClockB
);
  // protocol states
  localparam [2:0] ST_IDLE  = 3'h0;  // waiting for start
  localparam [2:0] ST_RX    = 3'h1;  // shifting a byte in
  localparam [2:0] ST_ACK   = 3'h2;  // device drives acknowledge
  localparam [2:0] ST_TX    = 3'h3;  // shifting a byte out
  localparam [2:0] ST_HACK  = 3'h4;  // host acknowledge slot

  wire       scl;                 // filtered serial clock
  wire       sda;                 // filtered serial data
  wire [3:0] fsSync;              // filtered select straps
  reg        sclPrev_q;           // for edge detection
  reg        sdaPrev_q;
  reg  [2:0] state_q;             // protocol state
  reg  [3:0] bitCnt_q;            // bits done in this byte
  reg  [7:0] shift_q;             // receive or transmit shifter
  reg        addrPhase_q;         // next received byte is address
  reg        reading_q;           // block read in progress
  reg  [3:0] byteIdx_q;           // bytes done after the address
  reg        sdaOe_q;             // pulling data low
  reg        sdaOut_q;            // open-drain level, always low
  reg  [7:0] func_q;              // byte zero, stored only
  reg  [7:0] cpuEn_q;
  reg  [7:0] pciEn_q;
  reg  [7:0] memEn_q;
  reg  [7:0] perEn_q;
  reg  [3:0] fsLatched_q;         // straps caught after reset
  reg  [2:0] waitCnt_q;           // sync settling counter
  reg        fsDone_q;            // straps captured once
  reg  [7:0] txByte;              // byte to send next

  // gated output flops
  reg        memF_q, procStop_q, procFree_q, busFree_q;
  reg  [4:0] bus_q;
  reg        c48_q, c24_q, intc_q, refA_q, refB_q;
  reg [11:0] memGrp_q;

  wire sclRise = scl & ~sclPrev_q;
  wire sclFall = ~scl & sclPrev_q;
  wire startCond = scl & sclPrev_q & sdaPrev_q & ~sda;
  wire stopCond  = scl & sclPrev_q & ~sdaPrev_q & sda;

  // serial pins are asynchronous; idle high
  ceb_sync #(.W(2), .INIT(1'b1)) u_syncBus (
    .clk  (clk),
    .nrst (nrst),
    .din  ({sclIn, sdaIn}),
    .dout ({scl, sda})
  );

  // select straps are asynchronous too
  ceb_sync #(.W(4), .INIT(1'b0)) u_syncSel (
    .clk  (clk),
    .nrst (nrst),
    .din  (freqSelectPins),
    .dout (fsSync)
  );

  // read-back value of a data byte; reserved bits read one
  function [7:0] readByte;
    input [2:0] idx;
    begin
      case (idx)
        `CEB_IDX_FUNC: readByte = func_q;
        `CEB_IDX_CPU: begin
          readByte = cpuEn_q;
          readByte[`CEB_CPU_SEL2] = ~fsLatched_q[2];
        end
        `CEB_IDX_PCI: readByte = pciEn_q;
        `CEB_IDX_MEM: begin
          readByte = memEn_q;
          readByte[`CEB_MEM_SEL0] = ~fsLatched_q[0];
        end
        `CEB_IDX_SEL: begin
          readByte = `CEB_RST_ENABLES;
          readByte[`CEB_SEL_SEL1] = ~fsLatched_q[1];
          readByte[`CEB_SEL_SEL3] = ~fsLatched_q[3];
        end
        `CEB_IDX_PERIPH: readByte = perEn_q;
        default: readByte = 8'h00;
      endcase
    end
  endfunction

  // merge written data into writable bits only
  function [7:0] merge;
    input [7:0] data;
    input [7:0] mask;
    begin
      merge = (data & mask) | ~mask;
    end
  endfunction

  // read sequence: count first, then bytes zero to five
  always @* begin
    if (byteIdx_q == 4'h0) begin
      txByte = `CEB_READ_COUNT;
    end else if (byteIdx_q <= 4'h6) begin
      txByte = readByte(byteIdx_q[2:0] - 3'h1);
    end else begin
      txByte = 8'hff;  // past the end, bus stays released
    end
  end

  // strap capture once the synchroniser has settled after reset
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitCnt_q   <= 3'h0;
      fsDone_q    <= 1'b0;
      fsLatched_q <= 4'h0;
    end else if (!fsDone_q) begin
      if (waitCnt_q == `CEB_LATCH_WAIT) begin
        fsLatched_q <= fsSync;
        fsDone_q    <= 1'b1;
      end else begin
        // capturing one edge early would latch the filter's reset level
        waitCnt_q <= waitCnt_q + 3'h1;
      end
    end
  end

  // serial slave: edges taken from the filtered lines
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclPrev_q   <= 1'b1;
      sdaPrev_q   <= 1'b1;
      state_q     <= ST_IDLE;
      bitCnt_q    <= 4'h0;
      shift_q     <= 8'h00;
      addrPhase_q <= 1'b0;
      reading_q   <= 1'b0;
      byteIdx_q   <= 4'h0;
      sdaOe_q     <= 1'b0;
      sdaOut_q    <= 1'b0;
      func_q      <= `CEB_RST_FUNC;
      cpuEn_q     <= `CEB_RST_ENABLES;
      pciEn_q     <= `CEB_RST_ENABLES;
      memEn_q     <= `CEB_RST_ENABLES;
      perEn_q     <= `CEB_RST_ENABLES;
    end else begin
      sclPrev_q <= scl;
      sdaPrev_q <= sda;
      sdaOut_q  <= 1'b0;  // open drain: only the enable moves
      if (stopCond) begin
        // stop ends any transfer; bytes already taken stay loaded
        state_q <= ST_IDLE;
        sdaOe_q <= 1'b0;
      end else if (startCond) begin
        // start or repeated start opens a fresh address phase
        state_q     <= ST_RX;
        bitCnt_q    <= 4'h0;
        addrPhase_q <= 1'b1;
        sdaOe_q     <= 1'b0;
      end else begin
        case (state_q)
          ST_RX: begin
            if (sclRise && bitCnt_q < 4'h8) begin
              shift_q  <= {shift_q[6:0], sda};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == 4'h8) begin
              bitCnt_q <= 4'h0;
              if (addrPhase_q) begin
                addrPhase_q <= 1'b0;
                byteIdx_q   <= 4'h0;
                if (shift_q == `CEB_ADDR_WRITE) begin
                  reading_q <= 1'b0;
                  sdaOe_q   <= 1'b1;
                  state_q   <= ST_ACK;
                end else if (shift_q == `CEB_ADDR_READ) begin
                  reading_q <= 1'b1;
                  sdaOe_q   <= 1'b1;
                  state_q   <= ST_ACK;
                end else begin
                  state_q <= ST_IDLE;  // not ours, stay silent
                end
              end else begin
                // command and count are acknowledged and dropped
                sdaOe_q <= 1'b1;
                state_q <= ST_ACK;
                if (byteIdx_q != 4'hf) begin
                  byteIdx_q <= byteIdx_q + 4'h1;
                end
                case (byteIdx_q)
                  4'h2: func_q  <= shift_q;
                  4'h3: cpuEn_q <= merge(shift_q, `CEB_WMASK_CPU);
                  4'h4: pciEn_q <= merge(shift_q, `CEB_WMASK_PCI);
                  4'h5: memEn_q <= merge(shift_q, `CEB_WMASK_MEM);
                  4'h7: perEn_q <= merge(shift_q, `CEB_WMASK_PERIPH);
                  default: ;  // byte four is read-only, extras ignored
                endcase
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              if (reading_q) begin
                // first data bit goes out on the same falling edge
                shift_q <= txByte;
                sdaOe_q <= ~txByte[7];
                state_q <= ST_TX;
              end else begin
                sdaOe_q <= 1'b0;
                state_q <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (sclFall) begin
              if (bitCnt_q == 4'h7) begin
                bitCnt_q  <= 4'h0;
                sdaOe_q   <= 1'b0;  // release for host acknowledge
                byteIdx_q <= byteIdx_q + 4'h1;
                state_q   <= ST_HACK;
              end else begin
                bitCnt_q <= bitCnt_q + 4'h1;
                shift_q  <= {shift_q[6:0], 1'b1};
                sdaOe_q  <= ~shift_q[6];
              end
            end
          end
          ST_HACK: begin
            // a high level on the rise is a not-acknowledge
            if (sclRise) begin
              if (sda) begin
                state_q <= ST_IDLE;
              end
            end else if (sclFall) begin
              shift_q <= txByte;
              sdaOe_q <= ~txByte[7];
              state_q <= ST_TX;
            end
          end
          default: begin
            sdaOe_q <= 1'b0;  // idle or unknown: bus released
          end
        endcase
      end
    end
  end

  // output gating; a cleared enable forces a steady low
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      memF_q     <= 1'b0;
      procStop_q <= 1'b0;
      procFree_q <= 1'b0;
      busFree_q  <= 1'b0;
      bus_q      <= 5'h00;
      c48_q      <= 1'b0;
      c24_q      <= 1'b0;
      memGrp_q   <= 12'h000;
      intc_q     <= 1'b0;
      refA_q     <= 1'b0;
      refB_q     <= 1'b0;
    end else begin
      memF_q     <= memClkSrc & cpuEn_q[`CEB_CPU_MEMF];
      procStop_q <= procClkSrc & cpuEn_q[`CEB_CPU_STOP];
      procFree_q <= procClkSrc & cpuEn_q[`CEB_CPU_FREE];
      busFree_q  <= busClkSrc & pciEn_q[`CEB_PCI_FREE];
      bus_q      <= {5{busClkSrc}} & pciEn_q[4:0];
      c48_q      <= clk48Src & memEn_q[`CEB_MEM_48];
      c24_q      <= clk24Src & memEn_q[`CEB_MEM_24];
      memGrp_q   <= {12{memClkSrc}} & {{4{memEn_q[`CEB_MEM_G2]}},
                    {4{memEn_q[`CEB_MEM_G1]}}, {4{memEn_q[`CEB_MEM_G0]}}};
      intc_q     <= refClkSrc & perEn_q[`CEB_PER_INTC];
      refB_q     <= refClkSrc & perEn_q[`CEB_PER_REFB];
      refA_q     <= refClkSrc & perEn_q[`CEB_PER_REFA];
    end
  end

  assign sdaOut             = sdaOut_q;
  assign sdaOe              = sdaOe_q;
  assign freeMemoryClock    = memF_q;
  assign stoppableProcClock = procStop_q;
  assign freeProcClock      = procFree_q;
  assign freeBusClock       = busFree_q;
  assign busClockOutputs    = bus_q;
  assign clk48Out           = c48_q;
  assign clk24Out           = c24_q;
  assign memClockGroups     = memGrp_q;
  assign interruptCtrlClock = intc_q;
  assign referenceClockA    = refA_q;
  assign referenceClockB    = refB_q;
endmodule // ceb_bank

// ### verification/ceb_bank_chk.sv
// port-level assertion checker for the clock output enable bank
`timescale 1ns/1ps
module ceb_bank_chk (
  // clock, reset and serial pins
  input wire        clk, nrst, sclIn, sdaIn, sdaOut, sdaOe,
  input wire [3:0]  freqSelectPins,
  // ungated sources
  input wire        procClkSrc, busClkSrc, memClkSrc, clk48Src, clk24Src, refClkSrc,
  // gated outputs
  input wire        freeMemoryClock, stoppableProcClock, freeProcClock, freeBusClock,
  input wire [4:0]  busClockOutputs,
  input wire        clk48Out, clk24Out, interruptCtrlClock, referenceClockA, referenceClockB,
  input wire [11:0] memClockGroups
);
  // one domain, all checks quiet during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // a gated output is high only one cycle after its source was high
  AST_PROC_GATE: assert property ((freeProcClock || stoppableProcClock) |-> $past(procClkSrc))
    else $error("cpu clock high without source");
  AST_BUS_GATE: assert property ((freeBusClock || |busClockOutputs) |-> $past(busClkSrc))
    else $error("bus clock high without source");
  AST_FIXED_GATE: assert property (({clk48Out, clk24Out} & ~{$past(clk48Src), $past(clk24Src)}) == 2'b00)
    else $error("fixed clock high without source");
  AST_GROUP_GATE: assert property (|memClockGroups |-> $past(memClkSrc))
    else $error("memory group high without source");
  // each group of four shares one enable bit
  AST_GROUP_EVEN: assert property (memClockGroups == {{4{memClockGroups[8]}}, {4{memClockGroups[4]}}, {4{memClockGroups[0]}}})
    else $error("memory group split");
  AST_REF_GATE: assert property ((interruptCtrlClock || referenceClockA || referenceClockB) |-> $past(refClkSrc))
    else $error("reference clock high without source");
  // open drain: only ever pulls low
  AST_SDA_LOW: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  // device changes the data line only while the serial clock is low
  AST_OE_SCL: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data line moved with serial clock high");
  AST_OE_BOUND: assert property ($rose(sdaOe) |-> ##[1:1000] !sdaOe)
    else $error("data line held too long");
endmodule // ceb_bank_chk

bind ceb_bank ceb_bank_chk u_chk (.*);

// ### verification/ceb_host.sv
// serial programming host model, open-drain data, clock idles high
`timescale 1ns/1ps
module ceb_host (
  // clock and resolved data line
  input  wire        clk,
  input  wire        sdaLine,
  // pins driven, 1 means released
  output logic       scl,
  output logic       sda,
  // byte read back, one-cycle strobe
  output logic [7:0] got,
  output logic       gotV
);
  int halfT = 12; // phase length in cycles, filter needs at least 6
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    got = 8'h00;
    gotV = 1'b0;
  end
  // all pin changes land just after a falling edge
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // start: data falls with clock high
  task automatic start();
    sda = 1'b1;
    scl = 1'b1;
    hold(halfT);
    sda = 1'b0;
    hold(halfT);
    scl = 0;
    hold(halfT);
  endtask
  // stop: data rises with clock high, clock then stands still
  task automatic stop();
    sda = 1'b0;
    hold(halfT);
    scl = 1'b1;
    hold(halfT);
    sda = 1'b1;
    hold(halfT);
  endtask
  // one bit; line sampled just before the clock falls
  task automatic bitx(input logic b, output logic r);
    sda = b;
    hold(halfT);
    scl = 1'b1;
    hold(halfT);
    r = sdaLine;
    scl = 1'b0;
    hold(halfT);
  endtask
  // byte out msb first, ack is the device pulling low
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // byte in, then acknowledge or not
  task automatic rbyte(output logic [7:0] b, input logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      b[i] = r;
    end
    bitx(~ok, r);
    got = b;
    gotV = 1'b1;
    hold(1);
    gotV = 1'b0;
  endtask
endmodule // ceb_host

// ### verification/testbench.sv
// self-checking bench for the clock output enable bank
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, nrst = 1'b0, srcHold = 1'b0;
  logic [3:0]  freqSelectPins = 4'h0;
  logic [5:0]  src = 6'h00;
  wire         sclIn, sdaIn, sdaOut, sdaOe, hostSda, gotV;
  wire  [7:0]  got;
  wire         procClkSrc = src[0], busClkSrc = src[1], memClkSrc = src[2];
  wire         clk48Src = src[3], clk24Src = src[4], refClkSrc = src[5];
  wire         freeMemoryClock, stoppableProcClock, freeProcClock, freeBusClock;
  wire         clk48Out, clk24Out, interruptCtrlClock, referenceClockA, referenceClockB;
  wire  [4:0]  busClockOutputs;
  wire  [11:0] memClockGroups;
  wire  [13:0] outs = {freeMemoryClock, stoppableProcClock, freeProcClock, freeBusClock,
                       busClockOutputs, clk48Out, clk24Out, interruptCtrlClock,
                       referenceClockB, referenceClockA};
  logic [7:0]  img [0:5];   // expected register image
  logic [7:0]  wd [0:6];    // bytes of the next write
  logic [7:0]  wm [0:5] = '{8'hff, 8'h0b, 8'h5f, 8'h37, 8'h00, 8'h13}; // stored bits
  logic [7:0]  expQ [$];    // expected read bytes
  int          fails = 0, tests_run = 0, cyc = 0;

  // open-drain line with pull-up
  assign sdaIn = hostSda & (sdaOe ? sdaOut : 1'b1);
  ceb_bank DUT (.*);
  ceb_host host (.clk(clk), .sdaLine(sdaIn), .scl(sclIn), .sda(hostSda), .got(got), .gotV(gotV));

  always #5 clk = ~clk;
  // sources toggle at random unless held high for a level check
  always @(negedge clk) src <= srcHold ? 6'h3f : 6'($urandom);

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    tests_run++;
    if (seen !== want) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // byte that the device must acknowledge
  task automatic send(input logic [7:0] b);
    logic a;
    host.wbyte(b, a);
    check({15'h0, a}, 16'h1, "ack");
  endtask
  // block read of count, six bytes and one past the end
  task automatic readAll();
    logic [7:0] rb;
    host.start();
    send(8'hd3);
    expQ.push_back(8'h06);
    for (int i = 0; i < 6; i++) expQ.push_back(img[i]);
    expQ.push_back(8'hff);
    for (int i = 0; i < 8; i++) host.rbyte(rb, i < 7);
    host.stop();
  endtask
  // block write of n data bytes, the stop may cut it short
  task automatic writeN(input int n);
    host.start();
    send(8'hd2);
    send(8'h5a);
    send(8'h06);
    for (int i = 0; i < n; i++) send(wd[i]);
    host.stop();
    for (int i = 0; i < n && i < 6; i++) img[i] = (img[i] & ~wm[i]) | (wd[i] & wm[i]);
  endtask
  // disabled outputs never rise; enabled ones follow a high source
  task automatic checkOuts();
    logic [13:0] want, acc;
    logic [11:0] wantM, accM;
    want = {img[1][3], img[1][1], img[1][0], img[2][6], img[2][4:0], img[3][5], img[3][4],
            img[5][4], img[5][1], img[5][0]};
    wantM = {{4{img[3][2]}}, {4{img[3][1]}}, {4{img[3][0]}}};
    acc = 14'h0000;
    accM = 12'h000;
    repeat (20) begin
      @(negedge clk);
      acc |= outs;
      accM |= memClockGroups;
    end
    check({2'b00, acc & ~want}, 16'h0000, "held low");
    check({4'h0, accM & ~wantM}, 16'h0000, "groups held low");
    srcHold = 1'b1;
    repeat (3) @(negedge clk);
    check({2'b00, outs}, {2'b00, want}, "outputs");
    check({4'h0, memClockGroups}, {4'h0, wantM}, "groups");
    srcHold = 1'b0;
  endtask
  // power-up image: enables set, byte0 clear, status bits from the straps
  task automatic setImg();
    img = '{8'h00, {~freqSelectPins[2], 7'h7f}, 8'hff, {1'b1, ~freqSelectPins[0], 6'h3f},
            {4'hf, ~freqSelectPins[1], 1'b1, ~freqSelectPins[3], 1'b1}, 8'hff};
  endtask

  // results come back in order as bytes are read
  always @(posedge clk) if (gotV === 1'b1) check({8'h00, got}, {8'h00, expQ.pop_front()}, "read");
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    logic a;
    void'($urandom(32'hc36b));
    freqSelectPins = 4'($urandom);
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    setImg();
    // straps move after capture; read-back must keep the latched value
    freqSelectPins = ~freqSelectPins;
    readAll();
    checkOuts();
    // foreign address is left unanswered
    host.start();
    host.wbyte(8'ha4, a);
    host.stop();
    check({15'h0, a}, 16'h0, "foreign nack");
    // all off, long with extra byte, short and slow, all on
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 7; i++) wd[i] = (r == 0) ? 8'h00 : (r == 3) ? 8'hff : 8'($urandom);
      host.halfT = (r == 2) ? 30 : 12;
      writeN((r == 1) ? 7 : (r == 2) ? 2 : 6);
      checkOuts();
      readAll();
    end
    // reset in mid-run restores every default and recaptures the straps
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    setImg();
    readAll();
    checkOuts();
    print_verdict();
  end
endmodule // testbench
